/* crp_peak_results.sv */
`timescale 1ns/100ps
module crp_peak_results #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic diag_store,
    input wire crp_pkg::crp_peaks_s diag_peaks,
    output logic capture_enable
);

    // Address decode needs paddr[11:2]; a narrower bus cannot reach the map
    if (ADDR_W < 12) begin : g_addr_check
        $error("ADDR_W must be at least 12");
    end
    // The map packs four locations and two sets of five heights, two per word
    if (crp_pkg::D_LOC_N != 4 || crp_pkg::AMP_N != 5) begin : g_count_check
        $error("result field counts do not match the register map");
    end
    if (crp_pkg::LOC_W > 8 || crp_pkg::AMP_W > 7) begin : g_width_check
        $error("result fields wider than their register slots");
    end

    crp_pkg::crp_peaks_s peaks_reg;
    crp_pkg::crp_peaks_s peaks_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic capture_reg;
    logic capture_next;
    logic valid_flag;
    logic drop_flag;
    logic valid_clear;
    logic drop_clear;
    logic drop_set;

    logic [9:0] idx;
    logic upper_zero;
    logic hit;
    logic [31:0] rd_word;
    logic access_first;
    logic done;
    logic wr_ctrl;
    logic wr_status;
    logic take;

    // Named view of the stored result set
    logic [crp_pkg::LOC_W-1:0] pair_d_second_peak_distance;
    logic [crp_pkg::LOC_W-1:0] pair_d_third_peak_distance;
    logic [crp_pkg::LOC_W-1:0] pair_d_fourth_peak_distance;
    logic [crp_pkg::LOC_W-1:0] pair_d_fifth_peak_distance;
    logic [crp_pkg::AMP_W-1:0] pair_a_first_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_a_second_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_a_third_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_a_fourth_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_a_fifth_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_b_first_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_b_second_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_b_third_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_b_fourth_peak_height;
    logic [crp_pkg::AMP_W-1:0] pair_b_fifth_peak_height;

    // Register images ahead of the read multiplexer
    logic [15:0] loc_mid_word;
    logic [15:0] loc_late_word;
    logic [15:0] amp_a_first_word;
    logic [15:0] amp_a_middle_word;
    logic [15:0] amp_boundary_word;
    logic [15:0] amp_b_middle_word;
    logic [15:0] amp_b_last_word;

    assign idx = paddr[11:2];
    assign upper_zero = ((paddr >> 12) == '0) && (paddr[1:0] == 2'b00);
    // One wait state lets read data leave from a flop
    assign access_first = psel && penable && !pready_reg;
    assign done = psel && penable && pready_reg;

    assign pair_d_second_peak_distance = peaks_reg.d_loc[0];
    assign pair_d_third_peak_distance = peaks_reg.d_loc[1];
    assign pair_d_fourth_peak_distance = peaks_reg.d_loc[2];
    assign pair_d_fifth_peak_distance = peaks_reg.d_loc[3];
    assign pair_a_first_peak_height = peaks_reg.a_amp[0];
    assign pair_a_second_peak_height = peaks_reg.a_amp[1];
    assign pair_a_third_peak_height = peaks_reg.a_amp[2];
    assign pair_a_fourth_peak_height = peaks_reg.a_amp[3];
    assign pair_a_fifth_peak_height = peaks_reg.a_amp[4];
    assign pair_b_first_peak_height = peaks_reg.b_amp[0];
    assign pair_b_second_peak_height = peaks_reg.b_amp[1];
    assign pair_b_third_peak_height = peaks_reg.b_amp[2];
    assign pair_b_fourth_peak_height = peaks_reg.b_amp[3];
    assign pair_b_fifth_peak_height = peaks_reg.b_amp[4];

    crp_field_pair #(
        .FIELD_W(crp_pkg::LOC_W)
    ) i_loc_mid (
        .low_field(pair_d_second_peak_distance),
        .high_field(pair_d_third_peak_distance),
        .packed_word(loc_mid_word)
    );

    crp_field_pair #(
        .FIELD_W(crp_pkg::LOC_W)
    ) i_loc_late (
        .low_field(pair_d_fourth_peak_distance),
        .high_field(pair_d_fifth_peak_distance),
        .packed_word(loc_late_word)
    );

    crp_field_pair #(
        .FIELD_W(crp_pkg::AMP_W)
    ) i_amp_a_first (
        .low_field(pair_a_first_peak_height),
        .high_field(pair_a_second_peak_height),
        .packed_word(amp_a_first_word)
    );

    crp_field_pair #(
        .FIELD_W(crp_pkg::AMP_W)
    ) i_amp_a_middle (
        .low_field(pair_a_third_peak_height),
        .high_field(pair_a_fourth_peak_height),
        .packed_word(amp_a_middle_word)
    );

    crp_field_pair #(
        .FIELD_W(crp_pkg::AMP_W)
    ) i_amp_boundary (
        .low_field(pair_a_fifth_peak_height),
        .high_field(pair_b_first_peak_height),
        .packed_word(amp_boundary_word)
    );

    crp_field_pair #(
        .FIELD_W(crp_pkg::AMP_W)
    ) i_amp_b_middle (
        .low_field(pair_b_second_peak_height),
        .high_field(pair_b_third_peak_height),
        .packed_word(amp_b_middle_word)
    );

    crp_field_pair #(
        .FIELD_W(crp_pkg::AMP_W)
    ) i_amp_b_last (
        .low_field(pair_b_fourth_peak_height),
        .high_field(pair_b_fifth_peak_height),
        .packed_word(amp_b_last_word)
    );

    always_comb begin
        rd_word = 32'h0000_0000;
        hit = upper_zero;
        case (idx)
            crp_pkg::IDX_D_LOC_MID: begin
                rd_word[15:0] = loc_mid_word;
            end
            crp_pkg::IDX_D_LOC_LATE: begin
                rd_word[15:0] = loc_late_word;
            end
            crp_pkg::IDX_AMP_A_FIRST: begin
                rd_word[15:0] = amp_a_first_word;
            end
            crp_pkg::IDX_AMP_A_MIDDLE: begin
                rd_word[15:0] = amp_a_middle_word;
            end
            crp_pkg::IDX_AMP_A_B_BOUNDARY: begin
                rd_word[15:0] = amp_boundary_word;
            end
            crp_pkg::IDX_AMP_B_MIDDLE: begin
                rd_word[15:0] = amp_b_middle_word;
            end
            crp_pkg::IDX_AMP_B_LAST: begin
                rd_word[15:0] = amp_b_last_word;
            end
            crp_pkg::IDX_CTRL: begin
                rd_word[crp_pkg::CTRL_CAPTURE_BIT] = capture_reg;
            end
            crp_pkg::IDX_STATUS: begin
                rd_word[crp_pkg::STAT_VALID_BIT] = valid_flag;
                rd_word[crp_pkg::STAT_DROP_BIT] = drop_flag;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Bus handshake and read data
    always_comb begin
        pready_next = access_first;
        pslverr_next = access_first && !hit;
        prdata_next = prdata_reg;
        if (access_first) begin
            prdata_next = (hit && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= crp_pkg::PRDATA_RST;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign wr_ctrl = done && pwrite && hit && (idx == crp_pkg::IDX_CTRL);
    assign wr_status = done && pwrite && hit && (idx == crp_pkg::IDX_STATUS);
    assign take = diag_store && capture_reg;

    // Write one to clear; a new event in the same cycle wins
    assign valid_clear = wr_status && pwdata[crp_pkg::STAT_VALID_BIT];
    assign drop_clear = wr_status && pwdata[crp_pkg::STAT_DROP_BIT];
    assign drop_set = diag_store && !capture_reg;

    crp_sticky_flag #(
        .RST_VAL(crp_pkg::STAT_RST)
    ) i_valid_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(take),
        .clear_req(valid_clear),
        .flag(valid_flag)
    );

    crp_sticky_flag #(
        .RST_VAL(crp_pkg::STAT_RST)
    ) i_drop_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(drop_set),
        .clear_req(drop_clear),
        .flag(drop_flag)
    );

    // Result store and capture enable
    always_comb begin
        peaks_next = peaks_reg;
        capture_next = capture_reg;
        if (take) begin
            peaks_next = diag_peaks;
        end
        if (wr_ctrl) begin
            capture_next = pwdata[crp_pkg::CTRL_CAPTURE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peaks_reg <= crp_pkg::PEAKS_RST;
            capture_reg <= crp_pkg::CTRL_CAPTURE_RST;
        end else begin
            peaks_reg <= peaks_next;
            capture_reg <= capture_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign capture_enable = capture_reg;

endmodule

// Two result fields side by side in one 16-bit image; spare top bits read zero
module crp_field_pair #(
    parameter int FIELD_W = 8
) (
    input wire logic [FIELD_W-1:0] low_field,
    input wire logic [FIELD_W-1:0] high_field,
    output logic [15:0] packed_word
);

    if (FIELD_W < 1 || FIELD_W > 8) begin : g_width_check
        $error("FIELD_W must be between 1 and 8");
    end

    always_comb begin
        packed_word = 16'h0000;
        packed_word[FIELD_W-1:0] = low_field;
        packed_word[FIELD_W+7:8] = high_field;
    end

endmodule

// Event flag cleared by writing one
module crp_sticky_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_evt,
    input wire logic clear_req,
    output logic flag
);

    logic flag_reg;
    logic flag_next;

    // Set wins: a lost event would hide a measurement, a lost clear only repeats one
    always_comb begin
        flag_next = flag_reg;
        if (clear_req) begin
            flag_next = 1'b0;
        end
        if (set_evt) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= RST_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule

/* crp_peak_results_asserts.sv */
`timescale 1ns/100ps
module crp_peak_results_asserts #(parameter int ADDR_W = 12) (
    input logic pclk, input logic presetn, input logic psel, input logic penable,
    input logic pwrite, input logic [ADDR_W-1:0] paddr, input logic [31:0] pwdata,
    input logic [31:0] prdata, input logic pready, input logic pslverr,
    input logic diag_store, input crp_pkg::crp_peaks_s diag_peaks,
    input logic capture_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic res;
    logic amp;
    // Aligned word inside the result window
    assign res = paddr[11:2] >= crp_pkg::IDX_D_LOC_MID && paddr[11:2] <= crp_pkg::IDX_AMP_B_LAST
        && paddr[1:0] == 2'b00;
    assign amp = res && paddr[11:2] >= crp_pkg::IDX_AMP_A_FIRST;
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_phase; pready |-> psel && penable; endproperty
    a_phase: assert property (p_phase) else $error("ready outside access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unal; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_unal: assert property (p_unal) else $error("unaligned not refused");
    property p_res_ok; pready && res |-> !pslverr; endproperty
    a_res_ok: assert property (p_res_ok) else $error("result access refused");
    property p_rsvd; pready && !pwrite && amp |-> prdata[31:15] == 0 && prdata[7] == 0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_ctrl;
        pready && pwrite && paddr[11:0] == {crp_pkg::IDX_CTRL, 2'b00}
            |=> capture_enable == $past(pwdata[0]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("capture enable not written");
endmodule
bind crp_peak_results crp_peak_results_asserts #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .diag_store(diag_store), .diag_peaks(diag_peaks), .capture_enable(capture_enable));

/* crp_pkg.sv */
package crp_pkg;

    // Field widths and counts of the stored results
    localparam int LOC_W = 8;
    localparam int AMP_W = 7;
    localparam int D_LOC_N = 4;
    localparam int AMP_N = 5;

    // Register indices; the byte address is four times the index
    localparam logic [9:0] IDX_D_LOC_MID = 10'h198;
    localparam logic [9:0] IDX_D_LOC_LATE = 10'h199;
    localparam logic [9:0] IDX_AMP_A_FIRST = 10'h19a;
    localparam logic [9:0] IDX_AMP_A_MIDDLE = 10'h19b;
    localparam logic [9:0] IDX_AMP_A_B_BOUNDARY = 10'h19c;
    localparam logic [9:0] IDX_AMP_B_MIDDLE = 10'h19d;
    localparam logic [9:0] IDX_AMP_B_LAST = 10'h19e;
    localparam logic [9:0] IDX_CTRL = 10'h1c0;
    localparam logic [9:0] IDX_STATUS = 10'h1c1;

    // Control and status bit positions
    localparam int CTRL_CAPTURE_BIT = 0;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_DROP_BIT = 1;

    // Reset values
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
    localparam logic CTRL_CAPTURE_RST = 1'b1;
    localparam logic STAT_RST = 1'b0;

    // Result set delivered by the measurement engine.
    // d_loc[0..3] are pair D peaks two to five; a_amp/b_amp hold peaks one to five.
    typedef struct packed {
        logic [D_LOC_N-1:0][LOC_W-1:0] d_loc;
        logic [AMP_N-1:0][AMP_W-1:0] a_amp;
        logic [AMP_N-1:0][AMP_W-1:0] b_amp;
    } crp_peaks_s;

    localparam crp_peaks_s PEAKS_RST = '0;

endpackage

/* tb.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, diag_store = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, seed = 32'h12125c5e;
    logic pready, pslverr, e, cap;
    crp_pkg::crp_peaks_s diag_peaks = '0, pk;
    logic [31:0] exp_w[7] = '{default: 0};
    int n_mismatch = 0, comparisons = 0;
    int m_cap = 1, m_stat = 0;
    crp_peak_results #(.ADDR_W(12)) i_crp_peak_results (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .diag_store(diag_store),
        .diag_peaks(diag_peaks), .capture_enable(cap));
    always #5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Only the watchdog ends a wait that never finishes
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; e = pslverr; psel <= 0; penable <= 0;
    endtask
    task automatic store();
        logic [127:0] w;
        int a[10];
        for (int k = 0; k < 4; k++) begin seed = lfsr(seed); w = {w[95:0], seed}; end
        pk = w[101:0];
        @(posedge pclk);
        diag_peaks <= pk; diag_store <= 1;
        @(posedge pclk);
        diag_store <= 0;
        // A store while capture is off only raises the dropped flag
        if (m_cap == 0) begin m_stat = m_stat | 2; return; end
        m_stat = m_stat | 1;
        for (int k = 0; k < 5; k++) begin a[k] = pk.a_amp[k]; a[k+5] = pk.b_amp[k]; end
        exp_w[0] = pk.d_loc[1] * 256 + pk.d_loc[0];
        exp_w[1] = pk.d_loc[3] * 256 + pk.d_loc[2];
        for (int k = 0; k < 5; k++) exp_w[2+k] = a[2*k+1] * 256 + a[2*k];
    endtask
    task automatic chk_all();
        for (int i = 0; i < 7; i++) begin
            apb(0, {crp_pkg::IDX_D_LOC_MID + 10'(i), 2'b00}, '0);
            `CHK("result", exp_w[i], q)
        end
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        chk_all();
        `CHK("capture", m_cap, cap)
        store();
        chk_all();
        apb(0, {crp_pkg::IDX_STATUS, 2'b00}, '0);
        `CHK("status", m_stat, q)
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            apb(1, {crp_pkg::IDX_D_LOC_MID + 10'(i), 2'b00}, seed);
            `CHK("write err", 1'b0, e)
        end
        chk_all();
        apb(1, {crp_pkg::IDX_CTRL, 2'b00}, '0);
        m_cap = 0;
        apb(0, {crp_pkg::IDX_CTRL, 2'b00}, '0);
        `CHK("capture", m_cap, cap)
        `CHK("ctrl", m_cap, q)
        store();
        chk_all();
        apb(0, {crp_pkg::IDX_STATUS, 2'b00}, '0);
        `CHK("status", m_stat, q)
        apb(1, {crp_pkg::IDX_STATUS, 2'b00}, 32'h0000_0003);
        m_stat = m_stat & ~3;
        apb(0, {crp_pkg::IDX_STATUS, 2'b00}, '0);
        `CHK("status", m_stat, q)
        // A reset in mid-run must clear every result again
        @(posedge pclk);
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        exp_w = '{default: 0};
        m_cap = 1;
        m_stat = 0;
        chk_all();
        `CHK("capture", m_cap, cap)
        apb(0, {crp_pkg::IDX_STATUS, 2'b00}, '0);
        `CHK("status", m_stat, q)
        store();
        chk_all();
        apb(0, 12'h661, '0);
        `CHK("unaligned", 1'b1, e)
        `CHK("unaligned data", 32'h0000_0000, q)
        complete_run();
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule
